// ### common/alu_subset_pkg.sv
// Constants, operation codes and register map for the ALU subset datapath.
// Assumes an AXI4-Lite master with 32-bit data and word-aligned addresses.
// Overview of operation
// RULE1: Return pops the call stack into the program counter in two cycles, flags untouched.
// RULE2: Literal minus working register goes to working register; carry, digit carry, zero updated.
// RULE3: Rotate file register right through carry; old carry to bit 7; only carry changes.
// RULE4: File register minus working register goes to destination; carry, digit carry, zero updated.
// RULE5: Swap the two nibbles of the file register into destination; no flag changes.
// RULE6: Working register XOR literal goes to working register; only zero flag changes.
// RULE7: Working register XOR file register goes to destination; only zero flag changes.
// RULE8: Destination bit 0 selects working register, 1 selects the addressed file register.
// RULE9: Zero set on all-zero result; subtraction carries mean no borrow from bits 7, 3.
package alu_subset_pkg;

	// Operation codes written to the command register
	typedef enum logic [2:0] {
		op_none                  = 3'h0,
		op_return                = 3'h1,
		sub_acc_from_literal_op  = 3'h2,
		rotate_right_carry_op    = 3'h3,
		sub_acc_from_file_op     = 3'h4,
		nibble_swap_op           = 3'h5,
		xor_literal_op           = 3'h6,
		xor_file_op              = 3'h7
	} op_t;

	localparam int unsigned file_depth    = 128;
	localparam int unsigned stack_depth   = 8;
	localparam int unsigned return_cycles = 2;

	// Register byte addresses
	localparam logic [7:0] cmd_addr    = 8'h00;
	localparam logic [7:0] acc_addr    = 8'h04;
	localparam logic [7:0] status_addr = 8'h08;
	localparam logic [7:0] pc_addr     = 8'h0c;
	localparam logic [7:0] push_addr   = 8'h10;
	localparam logic [7:0] fwin_addr   = 8'h14;
	localparam logic [7:0] fdata_addr  = 8'h18;

	// Command register fields
	localparam int unsigned cmd_op_lsb   = 0;
	localparam int unsigned cmd_dest_bit = 3;
	localparam int unsigned cmd_lit_lsb  = 8;
	localparam int unsigned cmd_file_lsb = 16;

	// Status register fields
	localparam int unsigned st_carry_bit            = 0;
	localparam int unsigned st_digit_carry_flag_bit = 1;
	localparam int unsigned st_zero_bit             = 2;
	localparam int unsigned st_busy_bit             = 3;
	localparam int unsigned st_sdep_lsb             = 4;

	localparam logic [7:0]  acc_reset    = 8'h00;
	localparam logic [12:0] pc_reset     = 13'h0000;
	localparam logic [1:0]  resp_okay    = 2'b00;
	localparam logic [1:0]  resp_slverr  = 2'b10;

endpackage

// ### core/alu_subset.sv
// Execution datapath for return, subtract, rotate, swap and XOR operations.
// Assumes one AXI4-Lite master; commands start on a write to the command register.
//
// Chosen here: register access over AXI4-Lite and the address map.
module alu_subset
	import alu_subset_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        clk_en,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready
);

	logic [7:0]  file_q [file_depth];
	logic [7:0]  file_d [file_depth];
	logic [12:0] stack_q [stack_depth];
	logic [12:0] stack_d [stack_depth];
	logic [3:0]  sdep_q, sdep_d;
	logic [12:0] pc_q, pc_d;
	logic [7:0]  acc_q, acc_d;
	logic        carry_q, carry_d;
	logic        digit_carry_flag_q, digit_carry_flag_d;
	logic        zero_q, zero_d;
	logic        busy_q, busy_d;
	logic [6:0]  fwin_q, fwin_d;

	logic [7:0]  aw_q, aw_d;
	logic        aw_full_q, aw_full_d;
	logic [31:0] w_q, w_d;
	logic [3:0]  ws_q, ws_d;
	logic        w_full_q, w_full_d;
	logic        bvalid_q, bvalid_d;
	logic [1:0]  bresp_q, bresp_d;
	logic        rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0]  rresp_q, rresp_d;

	// Borrow-free subtraction: a - b with carry meaning no borrow
	// Packed as no-borrow from bit 7, no-borrow from bit 3, then the difference
	function automatic logic [9:0] sub8(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] full;
		logic [4:0] low;
		full = {1'b0, a} + {1'b0, ~b} + 9'h001;
		low  = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
		return {full[8], low[4], full[7:0]};              // [RULE9]
	endfunction

	function automatic logic known_addr(input logic [7:0] a);
		unique case (a)
			cmd_addr, acc_addr, status_addr, pc_addr,
			push_addr, fwin_addr, fdata_addr: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	// Operations that take a file operand and honour the destination bit
	function automatic logic is_file_op(input op_t o);
		return o == rotate_right_carry_op || o == sub_acc_from_file_op ||
			o == nibble_swap_op || o == xor_file_op;
	endfunction

	logic        wr_go;
	logic [7:0]  wbyte0;
	op_t         cmd_op;
	logic        cmd_dest;
	logic [7:0]  cmd_lit;
	logic [6:0]  cmd_file;
	logic [7:0]  fval;
	logic [9:0]  diff;
	logic [7:0]  result;

	// Readies drop while frozen: a request taken then would be lost,
	// since none of the capture registers move with clk_en low
	assign s_axi_awready = clk_en && !aw_full_q && !bvalid_q;
	assign s_axi_wready  = clk_en && !w_full_q && !bvalid_q;
	assign s_axi_arready = clk_en && !rvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;

	always_comb begin
		aw_d      = aw_q;
		aw_full_d = aw_full_q;
		w_d       = w_q;
		ws_d      = ws_q;
		w_full_d  = w_full_q;
		bvalid_d  = bvalid_q;
		bresp_d   = bresp_q;
		rvalid_d  = rvalid_q;
		rdata_d   = rdata_q;
		rresp_d   = rresp_q;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_d      = s_axi_awaddr;
			aw_full_d = 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_d      = s_axi_wdata;
			ws_d     = s_axi_wstrb;
			w_full_d = 1'b1;
		end
		// The write executes at the edge that raises its response
		wr_go = aw_full_q && w_full_q && !bvalid_q;
		if (wr_go) begin
			aw_full_d = 1'b0;
			w_full_d  = 1'b0;
			bvalid_d  = 1'b1;
			// A command arriving while a return is in flight is refused
			bresp_d   = (!known_addr(aw_q) || (aw_q == cmd_addr && busy_q)) ?
				resp_slverr : resp_okay;
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_d = 1'b1;
			rresp_d  = known_addr(s_axi_araddr) ? resp_okay : resp_slverr;
			// Write-only and unmapped offsets read as zero
			unique case (s_axi_araddr)
				acc_addr:    rdata_d = {24'h00_0000, acc_q};
				status_addr: rdata_d = {24'h00_0000, sdep_q, busy_q, zero_q,
					digit_carry_flag_q, carry_q};
				pc_addr:     rdata_d = {19'h0_0000, pc_q};
				fwin_addr:   rdata_d = {25'h000_0000, fwin_q};
				fdata_addr:  rdata_d = {24'h00_0000, file_q[fwin_q]};
				default:     rdata_d = 32'h0000_0000;
			endcase
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_q      <= 8'h00;
			aw_full_q <= 1'b0;
			w_q       <= 32'h0000_0000;
			ws_q      <= 4'h0;
			w_full_q  <= 1'b0;
			bvalid_q  <= 1'b0;
			bresp_q   <= resp_okay;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= resp_okay;
		end else if (clk_en) begin
			aw_q      <= aw_d;
			aw_full_q <= aw_full_d;
			w_q       <= w_d;
			ws_q      <= ws_d;
			w_full_q  <= w_full_d;
			bvalid_q  <= bvalid_d;
			bresp_q   <= bresp_d;
			rvalid_q  <= rvalid_d;
			rdata_q   <= rdata_d;
			rresp_q   <= rresp_d;
		end
	end

	// Datapath
	always_comb begin
		wbyte0   = w_q[7:0];
		cmd_op   = op_t'(w_q[cmd_op_lsb +: 3]);
		cmd_dest = w_q[cmd_dest_bit];
		cmd_lit  = w_q[cmd_lit_lsb +: 8];
		cmd_file = w_q[cmd_file_lsb +: 7];
		fval     = file_q[cmd_file];
		// Nothing moves unless a write or the pending pop says so
		file_d   = file_q;
		stack_d  = stack_q;
		sdep_d   = sdep_q;
		pc_d     = pc_q;
		acc_d    = acc_q;
		carry_d  = carry_q;
		digit_carry_flag_d = digit_carry_flag_q;
		zero_d   = zero_q;
		busy_d   = 1'b0;
		fwin_d   = fwin_q;
		diff     = 10'h000;
		result   = 8'h00;
		// Second cycle of a return finishes it
		if (busy_q) begin
			// An empty stack leaves the program counter where it is
			if (sdep_q != 4'h0) begin
				pc_d   = stack_q[3'(sdep_q - 4'h1)];             // [RULE1]
				sdep_d = sdep_q - 4'h1;
			end
		end
		if (wr_go && ws_q[0]) begin
			unique case (aw_q)
				cmd_addr: begin
					if (!busy_q) begin
						unique case (cmd_op)
							// The pop lands one edge later, so a return spans two cycles
							op_return: busy_d = 1'b1;           // [RULE1]
							sub_acc_from_literal_op: begin
								diff    = sub8(cmd_lit, acc_q);
								acc_d   = diff[7:0];              // [RULE2]
								carry_d = diff[9];
								digit_carry_flag_d = diff[8];
								zero_d  = diff[7:0] == 8'h00;     // [RULE9]
							end
							rotate_right_carry_op: begin
								result  = {carry_q, fval[7:1]};   // [RULE3]
								carry_d = fval[0];
							end
							sub_acc_from_file_op: begin
								diff    = sub8(fval, acc_q);
								result  = diff[7:0];              // [RULE4]
								carry_d = diff[9];
								digit_carry_flag_d = diff[8];
								zero_d  = diff[7:0] == 8'h00;
							end
							nibble_swap_op: result = {fval[3:0], fval[7:4]}; // [RULE5]
							xor_literal_op: begin
								acc_d  = acc_q ^ cmd_lit;         // [RULE6]
								zero_d = (acc_q ^ cmd_lit) == 8'h00;
							end
							xor_file_op: begin
								result = acc_q ^ fval;            // [RULE7]
								zero_d = (acc_q ^ fval) == 8'h00;
							end
							default: ;
						endcase
						// Only file operations honour the destination bit
						if (is_file_op(cmd_op)) begin
							if (cmd_dest) begin
								file_d[cmd_file] = result;        // [RULE8]
							end else begin
								acc_d = result;                   // [RULE8]
							end
						end
					end
				end
				acc_addr:   acc_d  = wbyte0;
				// Busy and stack depth are read-only; only the flags take the write
				status_addr: begin
					carry_d = wbyte0[st_carry_bit];
					digit_carry_flag_d = wbyte0[st_digit_carry_flag_bit];
					zero_d  = wbyte0[st_zero_bit];
				end
				pc_addr:    pc_d   = w_q[12:0];
				// Pushing onto a full stack drops the oldest level and shifts the others down one
				push_addr: begin
					if (sdep_q < 4'(stack_depth)) begin
						stack_d[3'(sdep_q)] = w_q[12:0];
						sdep_d = sdep_q + 4'h1;
					end else begin
						for (int i = 0; i < stack_depth - 1; i++)
							stack_d[i] = stack_q[i + 1];
						stack_d[stack_depth - 1] = w_q[12:0];
					end
				end
				fwin_addr:  fwin_d = w_q[6:0];
				fdata_addr: file_d[fwin_q] = wbyte0;
				default: ;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			// The file array clears too, so window reads never return unknowns
			for (int i = 0; i < file_depth; i++)
				file_q[i] <= 8'h00;
			for (int i = 0; i < stack_depth; i++)
				stack_q[i] <= 13'h0000;
			sdep_q  <= 4'h0;
			pc_q    <= pc_reset;
			acc_q   <= acc_reset;
			carry_q <= 1'b0;
			digit_carry_flag_q <= 1'b0;
			zero_q  <= 1'b0;
			busy_q  <= 1'b0;
			fwin_q  <= 7'h00;
		end else if (clk_en) begin
			file_q  <= file_d;
			stack_q <= stack_d;
			sdep_q  <= sdep_d;
			pc_q    <= pc_d;
			acc_q   <= acc_d;
			carry_q <= carry_d;
			digit_carry_flag_q <= digit_carry_flag_d;
			zero_q  <= zero_d;
			busy_q  <= busy_d;
			fwin_q  <= fwin_d;
		end
	end

endmodule // alu_subset

// ### tb/alu_subset_sva.sv
// Bus timing checker for the ALU subset datapath.
// Assumes it is bound to alu_subset and sees only that module's ports.
module alu_subset_sva
	import alu_subset_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        clk_en,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [7:0]  s_axi_araddr,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_b_hold; s_axi_bvalid && !s_axi_bready && clk_en |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
	property p_r_hold; s_axi_rvalid && !s_axi_rready && clk_en |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
	property p_w_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_w_block: assert property (p_w_block) else $error("write taken during response");
	property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_ar_block: assert property (p_ar_block) else $error("read taken during response");
	// Both write halves taken in one edge answer after one more enabled edge
	property p_w_lat; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && clk_en
		##1 clk_en |=> s_axi_bvalid; endproperty
	a_w_lat: assert property (p_w_lat) else $error("write response late");
	property p_r_lat; s_axi_arvalid && s_axi_arready && clk_en |=> s_axi_rvalid; endproperty
	a_r_lat: assert property (p_r_lat) else $error("read response late");
	property p_r_unmap; s_axi_arvalid && s_axi_arready && clk_en && s_axi_araddr > fdata_addr
		|=> s_axi_rresp == resp_slverr && s_axi_rdata == 32'h0000_0000; endproperty
	a_r_unmap: assert property (p_r_unmap) else $error("unmapped read not refused");
	property p_freeze; !clk_en |=> $stable(s_axi_bvalid) && $stable(s_axi_rvalid); endproperty
	a_freeze: assert property (p_freeze) else $error("state moved while frozen");
	property p_freeze_rdy; !clk_en |->
		!s_axi_awready && !s_axi_wready && !s_axi_arready; endproperty
	a_freeze_rdy: assert property (p_freeze_rdy) else $error("request accepted while frozen");
endmodule // alu_subset_sva

bind alu_subset alu_subset_sva chk_u (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// ### tb/alu_subset_tb_top.sv
// Self-checking bench for the ALU subset datapath over its register bus.
// Assumes it drives the ports itself and waits for each answer up to the 20000-cycle watchdog, except in the stall test, which samples at fixed cycles.
module alu_subset_tb_top
	import alu_subset_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
	logic        arvalid, arready, rvalid, en, bready, rready;
	logic [3:0]  wstrb;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [1:0]  bresp, rresp, r;
	int          fails, checked, cyc;

	alu_subset dut_u (.aclk(aclk), .aresetn(aresetn), .clk_en(en),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	task automatic results();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			fails++;
			$display("mismatch t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		chk({30'h0, bresp}, {30'h0, er});
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(d, e);
		chk({30'h0, r}, {30'h0, resp_okay});
	endtask

	function automatic logic [31:0] cm(op_t o, int dst, int k, int f);
		return {9'h0, 7'(f), 8'(k), 4'h0, 1'(dst), o};
	endfunction

	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			results();
		end
	end

	initial begin
		{aresetn, awvalid, wvalid, arvalid} = 4'h0;
		{en, bready, rready} = 3'b111;
		wstrb = 4'hf;
		{awaddr, araddr, wdata} = 48'h0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rc(acc_addr, 32'h0);
		rc(pc_addr, 32'h0);
		rc(status_addr, 32'h0);
		$display("reset test done");
		wr(8'h1c, 32'h1, resp_slverr);
		rd(8'h1c);
		chk({30'h0, r}, {30'h0, resp_slverr});
		chk(d, 32'h0);
		$display("bus test done");
		wr(acc_addr, 32'h05, resp_okay);
		wr(cmd_addr, cm(sub_acc_from_literal_op, 0, 8'h03, 0), resp_okay);
		rc(acc_addr, 32'hfe);
		rc(status_addr, 32'h0);
		wr(acc_addr, 32'h10, resp_okay);
		wr(cmd_addr, cm(sub_acc_from_literal_op, 0, 8'h10, 0), resp_okay);
		rc(acc_addr, 32'h0);
		rc(status_addr, 32'h7);
		wr(status_addr, 32'h6, resp_okay);
		wr(fwin_addr, 32'h7f, resp_okay);
		wr(fdata_addr, 32'h01, resp_okay);
		wr(cmd_addr, cm(rotate_right_carry_op, 1, 0, 7'h7f), resp_okay);
		rc(fdata_addr, 32'h0);
		rc(status_addr, 32'h7);
		wr(cmd_addr, cm(rotate_right_carry_op, 0, 0, 7'h7f), resp_okay);
		rc(acc_addr, 32'h80);
		rc(status_addr, 32'h6);
		wr(fdata_addr, 32'h20, resp_okay);
		wr(acc_addr, 32'h01, resp_okay);
		wr(cmd_addr, cm(sub_acc_from_file_op, 1, 0, 7'h7f), resp_okay);
		rc(fdata_addr, 32'h1f);
		rc(status_addr, 32'h1);
		wr(cmd_addr, cm(sub_acc_from_file_op, 0, 0, 7'h7f), resp_okay);
		rc(acc_addr, 32'h1e);
		rc(status_addr, 32'h3);
		$display("subtract test done");
		wr(cmd_addr, cm(nibble_swap_op, 0, 0, 7'h7f), resp_okay);
		rc(acc_addr, 32'hf1);
		rc(status_addr, 32'h3);
		wr(cmd_addr, cm(nibble_swap_op, 1, 0, 7'h7f), resp_okay);
		rc(fdata_addr, 32'hf1);
		wr(cmd_addr, cm(xor_literal_op, 0, 8'hf1, 0), resp_okay);
		rc(acc_addr, 32'h0);
		rc(status_addr, 32'h7);
		wr(cmd_addr, cm(xor_literal_op, 0, 8'h0f, 0), resp_okay);
		rc(status_addr, 32'h3);
		wr(cmd_addr, cm(xor_file_op, 1, 0, 7'h7f), resp_okay);
		rc(fdata_addr, 32'hfe);
		wr(cmd_addr, cm(xor_file_op, 0, 0, 7'h7f), resp_okay);
		rc(acc_addr, 32'hf1);
		rc(status_addr, 32'h3);
		$display("logic test done");
		wr(push_addr, 32'h1234, resp_okay);
		wr(push_addr, 32'h0abc, resp_okay);
		rc(status_addr, 32'h23);
		wr(cmd_addr, cm(op_return, 0, 0, 0), resp_okay);
		rc(pc_addr, 32'h0abc);
		rc(status_addr, 32'h13);
		wr(cmd_addr, cm(op_return, 0, 0, 0), resp_okay);
		rc(pc_addr, 32'h1234);
		$display("return test done");
		// The read answer must stand while the block is frozen, and both answers while the master stalls them
		{bready, rready} <= 2'b00;
		wstrb <= 4'he;
		awaddr <= acc_addr;
		wdata <= 32'h0000_0055;
		araddr <= acc_addr;
		{awvalid, wvalid, arvalid} <= 3'b111;
		@(posedge aclk);
		{awvalid, wvalid, arvalid} <= 3'b000;
		en <= 1'b0;
		chk({29'h0, awready, wready, arready}, 32'h0000_0007);
		repeat (2) @(posedge aclk);
		en <= 1'b1;
		repeat (2) @(posedge aclk);
		{bready, rready} <= 2'b11;
		@(posedge aclk);
		chk({30'h0, bvalid, rvalid}, 32'h0000_0003);
		chk({30'h0, bresp}, {30'h0, resp_okay});
		chk(rdata, 32'h0000_00f1);
		wstrb <= 4'hf;
		rc(acc_addr, 32'h0000_00f1);
		$display("stall test done");
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rc(pc_addr, 32'h0000_0000);
		rc(status_addr, 32'h0000_0000);
		rc(acc_addr, 32'h0000_0000);
		$display("second reset test done");
		results();
	end
endmodule // alu_subset_tb_top
